//--- dv/maf_axis_model.sv
`timescale 1ns/1ps
// ----------
// Servo amplifier model
// ----------
module maf_axis_model #(
    parameter int AXES = 32
) (
    // Clock and reset
    input logic core_clk_i,
    input logic rst_i,
    // Requests from the block
    input logic [AXES-1:0] jog_start_i,
    input logic [AXES-1:0] decel_stop_i,
    // Fault injection
    input logic [AXES-1:0] fault_i,
    // Amplifier status
    output logic [AXES-1:0] axis_moving_o,
    output logic [AXES-1:0] axis_servo_error_o
);
    // Moving from start pulse to stop pulse
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            axis_moving_o <= '0;
        end else begin
            axis_moving_o <= (axis_moving_o | jog_start_i) & ~decel_stop_i;
        end
    end

    // Errors lag a cycle, like a drive
    always_ff @(posedge core_clk_i) begin
        axis_servo_error_o <= rst_i ? '0 : fault_i;
    end
endmodule

//--- dv/maf_flags_props.sv
`timescale 1ns/1ps
// ----------
// Flag checker
// ----------
module maf_flags_props #(
    parameter int AXES = 32,
    parameter int AXES_VALID = 32,
    parameter int SLOTS = 8
) (
    // Clock and reset
    input logic core_clk_i,
    input logic rst_i,
    // Servo command
    input logic servo_on_wr_i,
    input logic servo_on_val_i,
    input logic forced_stop_i,
    input logic [AXES-1:0] axis_positioning_i,
    input logic all_axes_servo_on_cmd_o,
    input logic servo_on_accept_flag_o,
    input logic [AXES-1:0] servo_enable_o,
    // Slots and jog
    input logic [SLOTS-1:0] slot_configured_i,
    input logic [SLOTS-1:0] slot_module_bad_i,
    input logic slot_fault_flag_o,
    input logic start_lockout_o,
    input logic [AXES-1:0] axis_start_grant_o,
    input logic jog_simultaneous_start_cmd_i,
    input logic [63:0] jog_axis_select_words_i,
    input logic [AXES-1:0] jog_start_o,
    input logic [AXES-1:0] decel_stop_o,
    // Cycle and per-axis status
    input logic cycle_done_i,
    input logic [15:0] cycle_time_i,
    input logic [15:0] operation_cycle_setting_i,
    input logic user_program_reset_i,
    input logic cycle_overrun_flag_o,
    input logic [AXES-1:0] speed_change_instruction_i,
    input logic [AXES-1:0] host_speed_change_instruction_i,
    input logic [AXES-1:0] speed_change_accepting_flags_o,
    input logic [AXES-1:0] stop_decel_i,
    input logic [AXES-1:0] travel_zero_i,
    input logic [AXES-1:0] start_complete_i,
    input logic [AXES-1:0] auto_decelerating_flags_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    localparam logic [AXES-1:0] VM = AXES'((64'h1 << AXES_VALID) - 64'h1);
    logic [AXES-1:0] owned;
    wire busy = |(axis_positioning_i & VM);

    // Axes of the latest jog launch
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            owned <= '0;
        end else if (jog_start_o != '0) begin
            owned <= jog_start_o;
        end
    end

    sequence s_jog_rise;
        $rose(jog_simultaneous_start_cmd_i) && !slot_fault_flag_o && !start_lockout_o;
    endsequence

    a_cmd_taken: assert property (
        servo_on_wr_i && !forced_stop_i && !busy |=> all_axes_servo_on_cmd_o == $past(servo_on_val_i))
        else $error("servo command not taken");
    a_busy_ignored: assert property (
        servo_on_wr_i && busy && !forced_stop_i |=> $stable(all_axes_servo_on_cmd_o))
        else $error("command changed while busy");
    a_stop_clears: assert property (
        forced_stop_i |=> !all_axes_servo_on_cmd_o && servo_enable_o == '0)
        else $error("forced stop left servo on");
    a_accept_follows: assert property (
        all_axes_servo_on_cmd_o && !forced_stop_i |=> servo_on_accept_flag_o)
        else $error("accept flag missing");
    a_fault_tracks: assert property (
        1 |=> slot_fault_flag_o == $past(|(slot_module_bad_i & slot_configured_i)))
        else $error("slot fault flag wrong");
    a_lock_sticky: assert property (
        slot_fault_flag_o || start_lockout_o |=> start_lockout_o)
        else $error("lockout released");
    a_lock_refuses: assert property (
        start_lockout_o |-> axis_start_grant_o == '0 && jog_start_o == '0)
        else $error("start granted in lockout");
    a_jog_launch: assert property (
        s_jog_rise |=> jog_start_o == ($past(jog_axis_select_words_i[AXES-1:0]) & VM))
        else $error("jog start set wrong");
    a_jog_stop: assert property (
        $fell(jog_simultaneous_start_cmd_i) |=> (decel_stop_o & owned) == owned)
        else $error("jog axes not stopped");
    a_overrun_set: assert property (
        cycle_done_i && cycle_time_i > operation_cycle_setting_i |=> cycle_overrun_flag_o)
        else $error("overrun not flagged");
    a_overrun_held: assert property (
        cycle_overrun_flag_o && !user_program_reset_i |=> cycle_overrun_flag_o)
        else $error("overrun flag dropped");
    a_speed_cause: assert property (
        1 |=> (speed_change_accepting_flags_o & ~$past(speed_change_accepting_flags_o)
            & ~$past(speed_change_instruction_i & ~host_speed_change_instruction_i & VM)) == '0)
        else $error("speed flag without cause");
    a_decel_barred: assert property (
        1 |=> (auto_decelerating_flags_o & $past(stop_decel_i | travel_zero_i | start_complete_i)) == '0)
        else $error("decel flag in barred case");
endmodule

bind maf_flags maf_flags_props #(.AXES(AXES), .AXES_VALID(AXES_VALID), .SLOTS(SLOTS)) u_props (.*);

//--- dv/maf_flags_test.sv
`timescale 1ns/1ps
// ----------
// Flag block bench
// ----------
module maf_flags_test;
    import maf_pkg::*;
    localparam int AXES = 8;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic servo_on_wr_i, servo_on_val_i, forced_stop_i, run_stopped_i, jog_simultaneous_start_cmd_i;
    logic pulse_generator_enables_wr_i, cycle_done_i, user_program_reset_i;
    logic [AXES-1:0] axis_servo_off_cmd_i, axis_servo_error_i, axis_positioning_i, axis_moving_i;
    logic [AXES-1:0] axis_start_req_i, speed_change_instruction_i, host_speed_change_instruction_i;
    logic [AXES-1:0] speed_change_done_i, auto_decel_active_i, scurve_early_decel_i, stop_decel_i;
    logic [AXES-1:0] travel_zero_i, cmd_addr_change_i, start_complete_i, fault;
    logic [7:0] slot_configured_i, slot_module_bad_i, slot_use_req_i, slot_use_grant_o;
    logic [63:0] jog_axis_select_words_i;
    logic [2:0] pulse_generator_enables_val_i, pulse_generator_pulse_i;
    logic [2:0] pulse_generator_enables_o, pulse_generator_pulse_o;
    logic [15:0] cycle_time_i, operation_cycle_setting_i;
    maf_motion_mode_t axis_mode_i [AXES];
    logic all_axes_servo_on_cmd_o, servo_on_accept_flag_o, slot_fault_flag_o, start_lockout_o;
    logic cycle_overrun_flag_o;
    logic [AXES-1:0] servo_enable_o, axis_start_grant_o, jog_start_o, decel_stop_o;
    logic [AXES-1:0] speed_change_accepting_flags_o, auto_decelerating_flags_o;
    int fail_count = 0, num_checks = 0;

    // Four valid axes, so masking shows
    maf_flags #(.AXES(AXES), .AXES_VALID(4)) DUT (.*);
    maf_axis_model #(.AXES(AXES)) u_amp (.core_clk_i(core_clk_i), .rst_i(rst_i), .jog_start_i(jog_start_o),
        .decel_stop_i(decel_stop_o), .fault_i(fault), .axis_moving_o(axis_moving_i),
        .axis_servo_error_o(axis_servo_error_i));

    always #25 core_clk_i = ~core_clk_i;

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask

    task automatic check(input logic [63:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic servo_wr(input logic v);
        servo_on_wr_i = 1'b1;
        servo_on_val_i = v;
        tick(1);
        servo_on_wr_i = 1'b0;
        tick(1);
    endtask

    task automatic pulse_cycle(input logic [15:0] t);
        cycle_time_i = t;
        cycle_done_i = 1'b1;
        tick(1);
        cycle_done_i = 1'b0;
        tick(1);
    endtask

    task automatic set_mode(input maf_motion_mode_t m);
        foreach (axis_mode_i[i]) axis_mode_i[i] = m;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge core_clk_i);
        fail_count++;
        test_done();
    end

    // ----------
    // Main sequence
    // ----------
    initial begin
        {servo_on_wr_i, servo_on_val_i, forced_stop_i, run_stopped_i, jog_simultaneous_start_cmd_i} = '0;
        {pulse_generator_enables_wr_i, cycle_done_i, user_program_reset_i, axis_servo_off_cmd_i} = '0;
        {axis_positioning_i, axis_start_req_i, speed_change_instruction_i, fault} = '0;
        {host_speed_change_instruction_i, speed_change_done_i, auto_decel_active_i} = '0;
        {scurve_early_decel_i, stop_decel_i, travel_zero_i, cmd_addr_change_i, start_complete_i} = '0;
        {slot_module_bad_i, slot_use_req_i, jog_axis_select_words_i, cycle_time_i} = '0;
        {pulse_generator_enables_val_i, pulse_generator_pulse_i} = '0;
        slot_configured_i = 8'h0F;
        operation_cycle_setting_i = 16'h0100;
        set_mode(MAF_MODE_IDLE);
        tick(10);
        rst_i = 1'b0;
        tick(1);
        check(pulse_generator_enables_o, 3'h0);
        // Servo on, one axis off, one in error
        axis_servo_off_cmd_i = 8'h02;
        fault = 8'h04;
        servo_wr(1'b1);
        check(all_axes_servo_on_cmd_o, 1'h1);
        check(servo_on_accept_flag_o, 1'h1);
        check(servo_enable_o, 8'h09);
        axis_positioning_i = 8'h01;
        servo_wr(1'b0);
        check(all_axes_servo_on_cmd_o, 1'h1);
        axis_positioning_i = 8'h10;
        servo_wr(1'b0);
        check(all_axes_servo_on_cmd_o, 1'h0);
        axis_positioning_i = 8'h00;
        servo_wr(1'b1);
        run_stopped_i = 1'b1;
        tick(3);
        check(all_axes_servo_on_cmd_o, 1'h1);
        forced_stop_i = 1'b1;
        tick(1);
        forced_stop_i = 1'b0;
        check(all_axes_servo_on_cmd_o, 1'h0);
        check(servo_enable_o, 8'h00);
        // Pulse generator gating
        pulse_generator_enables_val_i = 3'h5;
        pulse_generator_enables_wr_i = 1'b1;
        tick(1);
        pulse_generator_enables_wr_i = 1'b0;
        pulse_generator_pulse_i = 3'h7;
        check(pulse_generator_enables_o, 3'h5);
        tick(1);
        check(pulse_generator_pulse_o, 3'h5);
        // Overrun boundary, sticky, user reset
        pulse_cycle(16'h0100);
        check(cycle_overrun_flag_o, 1'h0);
        pulse_cycle(16'h0101);
        tick(3);
        check(cycle_overrun_flag_o, 1'h1);
        user_program_reset_i = 1'b1;
        tick(1);
        user_program_reset_i = 1'b0;
        check(cycle_overrun_flag_o, 1'h0);
        // Speed change: host and invalid axis stay clear
        speed_change_instruction_i = 8'h23;
        host_speed_change_instruction_i = 8'h02;
        tick(1);
        {speed_change_instruction_i, host_speed_change_instruction_i} = '0;
        check(speed_change_accepting_flags_o, 8'h01);
        speed_change_done_i = 8'h01;
        tick(1);
        speed_change_done_i = 8'h00;
        check(speed_change_accepting_flags_o, 8'h00);
        // Deceleration in every mode
        auto_decel_active_i = 8'hFF;
        for (int m = 0; m < 6; m++) begin
            set_mode(maf_motion_mode_t'(m));
            tick(1);
            check(auto_decelerating_flags_o, (m >= 1 && m <= 3) ? 8'h0F : 8'h00);
        end
        set_mode(MAF_MODE_POSITIONING);
        stop_decel_i = 8'h01;
        travel_zero_i = 8'h02;
        start_complete_i = 8'h04;
        tick(1);
        {stop_decel_i, travel_zero_i, start_complete_i, auto_decel_active_i} = '0;
        check(auto_decelerating_flags_o, 8'h08);
        scurve_early_decel_i = 8'h01;
        tick(1);
        scurve_early_decel_i = 8'h00;
        check(auto_decelerating_flags_o, 8'h01);
        set_mode(MAF_MODE_FOLLOW_UP);
        auto_decel_active_i = 8'h0F;
        cmd_addr_change_i = 8'h08;
        tick(1);
        {cmd_addr_change_i, auto_decel_active_i} = '0;
        check(auto_decelerating_flags_o, 8'h07);
        // Jog, upper select bits ignored
        jog_axis_select_words_i = 64'h0000_0100_0000_00F3;
        jog_simultaneous_start_cmd_i = 1'b1;
        tick(1);
        check(jog_start_o, 8'h03);
        jog_simultaneous_start_cmd_i = 1'b0;
        tick(1);
        check(decel_stop_o, 8'h03);
        // Slot fault while axes move
        slot_module_bad_i = 8'h80;
        slot_use_req_i = 8'hFF;
        jog_simultaneous_start_cmd_i = 1'b1;
        tick(2);
        check(slot_fault_flag_o, 1'h0);
        check(slot_use_grant_o, 8'h0F);
        slot_module_bad_i = 8'h81;
        axis_start_req_i = 8'h0F;
        tick(1);
        check(slot_fault_flag_o, 1'h1);
        tick(1);
        check(decel_stop_o, 8'h03);
        check(start_lockout_o, 1'h1);
        slot_module_bad_i = 8'h80;
        tick(1);
        check(slot_fault_flag_o, 1'h0);
        tick(1);
        check(axis_start_grant_o, 8'h00);
        check(start_lockout_o, 1'h1);
        test_done();
    end
endmodule

//--- hdl/maf_axis_cell.sv
`timescale 1ns/1ps
`include "maf_map.svh"

module maf_axis_cell (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Axis valid in this variant
    input wire logic axis_valid_i,
    // Speed change sources
    input wire logic seq_speed_change_start_i,
    input wire logic host_speed_change_start_i,
    input wire logic speed_change_done_i,
    // Deceleration status
    input wire maf_pkg::maf_motion_mode_t mode_i,
    input wire logic auto_decel_active_i,
    input wire logic scurve_early_decel_i,
    input wire logic stop_decel_i,
    input wire logic travel_zero_i,
    input wire logic cmd_addr_change_i,
    input wire logic start_complete_i,
    // Flags
    output logic speed_change_accepting_o,
    output logic auto_decelerating_o
);
    import maf_pkg::*;

    logic mode_ok;
    logic next_decel;

    // Only positioning, follow-up and constant speed qualify
    always_comb begin
        unique case (mode_i)
            MAF_MODE_POSITIONING: mode_ok = 1'b1;
            MAF_MODE_FOLLOW_UP: mode_ok = 1'b1;
            MAF_MODE_CONST_SPEED: mode_ok = 1'b1;
            MAF_MODE_IDLE: mode_ok = 1'b0;
            MAF_MODE_JOG: mode_ok = 1'b0;
            MAF_MODE_PULSE_GEN: mode_ok = 1'b0;
            default: mode_ok = 1'b0;
        endcase
    end

    // Level follows deceleration; stops and zero travel never count
    always_comb begin
        next_decel = axis_valid_i & mode_ok & ~stop_decel_i & ~travel_zero_i
            & (auto_decel_active_i | scurve_early_decel_i);
        if (start_complete_i) begin
            next_decel = 1'b0;
        end
        if (cmd_addr_change_i && mode_i == MAF_MODE_FOLLOW_UP) begin
            next_decel = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            auto_decelerating_o <= 1'b0;
        end else begin
            auto_decelerating_o <= next_decel;
        end
    end

    // Host-issued change never raises the flag; set wins over done
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !axis_valid_i) begin
            speed_change_accepting_o <= 1'b0;
        end else if (seq_speed_change_start_i && !host_speed_change_start_i) begin
            speed_change_accepting_o <= 1'b1;
        end else if (speed_change_done_i) begin
            speed_change_accepting_o <= 1'b0;
        end
    end

endmodule

//--- hdl/maf_flags.sv
`timescale 1ns/1ps
`include "maf_map.svh"

module maf_flags #(
    parameter int AXES = `MAF_AXES_MAX,
    parameter int AXES_VALID = `MAF_AXES_MAX,
    parameter int SLOTS = `MAF_SLOTS,
    parameter int JOG_WORDS = `MAF_JOG_WORDS,
    parameter int JOG_WORD_W = `MAF_JOG_WORD_W,
    parameter int MPG_COUNT = `MAF_MPG_COUNT,
    parameter int CYCLE_W = `MAF_CYCLE_W
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,

    // Servo-on command from host
    input wire logic servo_on_wr_i,
    input wire logic servo_on_val_i,
    input wire logic forced_stop_i,
    input wire logic run_stopped_i,
    input wire logic [AXES-1:0] axis_servo_off_cmd_i,
    input wire logic [AXES-1:0] axis_servo_error_i,
    input wire logic [AXES-1:0] axis_positioning_i,

    // Slot supervision
    input wire logic [SLOTS-1:0] slot_configured_i,
    input wire logic [SLOTS-1:0] slot_module_bad_i,
    input wire logic [SLOTS-1:0] slot_use_req_i,
    input wire logic [AXES-1:0] axis_moving_i,
    input wire logic [AXES-1:0] axis_start_req_i,

    // Simultaneous jog
    input wire logic jog_simultaneous_start_cmd_i,
    input wire logic [JOG_WORDS*JOG_WORD_W-1:0] jog_axis_select_words_i,

    // Pulse generators
    input wire logic pulse_generator_enables_wr_i,
    input wire logic [MPG_COUNT-1:0] pulse_generator_enables_val_i,
    input wire logic [MPG_COUNT-1:0] pulse_generator_pulse_i,

    // Cycle supervision
    input wire logic cycle_done_i,
    input wire logic [CYCLE_W-1:0] cycle_time_i,
    input wire logic [CYCLE_W-1:0] operation_cycle_setting_i,
    input wire logic user_program_reset_i,

    // Per-axis speed change and deceleration status
    input wire logic [AXES-1:0] speed_change_instruction_i,
    input wire logic [AXES-1:0] host_speed_change_instruction_i,
    input wire logic [AXES-1:0] speed_change_done_i,
    input wire maf_pkg::maf_motion_mode_t axis_mode_i [AXES],
    input wire logic [AXES-1:0] auto_decel_active_i,
    input wire logic [AXES-1:0] scurve_early_decel_i,
    input wire logic [AXES-1:0] stop_decel_i,
    input wire logic [AXES-1:0] travel_zero_i,
    input wire logic [AXES-1:0] cmd_addr_change_i,
    input wire logic [AXES-1:0] start_complete_i,

    // Servo status
    output logic all_axes_servo_on_cmd_o,
    output logic servo_on_accept_flag_o,
    output logic [AXES-1:0] servo_enable_o,

    // Slot status
    output logic slot_fault_flag_o,
    output logic start_lockout_o,
    output logic [SLOTS-1:0] slot_use_grant_o,
    output logic [AXES-1:0] axis_start_grant_o,

    // Motion requests
    output logic [AXES-1:0] jog_start_o,
    output logic [AXES-1:0] decel_stop_o,

    // Pulse generator status
    output logic [MPG_COUNT-1:0] pulse_generator_enables_o,
    output logic [MPG_COUNT-1:0] pulse_generator_pulse_o,

    // Cycle status
    output logic cycle_overrun_flag_o,

    // Per-axis flags
    output logic [AXES-1:0] speed_change_accepting_flags_o,
    output logic [AXES-1:0] auto_decelerating_flags_o
);
    import maf_pkg::*;

    // ----------------------------------------
    // Common terms
    // ----------------------------------------
    logic [AXES-1:0] axis_valid;
    logic any_positioning;
    logic slot_bad_now;
    logic slot_fault_prev;
    logic slot_fault_edge;
    logic jog_cmd_prev;
    logic jog_rise;
    logic jog_fall;
    logic [AXES-1:0] jog_select;
    logic [AXES-1:0] jog_owned;
    logic overrun_now;

    // Axes beyond the variant size stay inert
    genvar g;
    generate
        for (g = 0; g < AXES; g = g + 1) begin : g_valid
            assign axis_valid[g] = (g < AXES_VALID);
        end
    endgenerate

    assign any_positioning = |(axis_positioning_i & axis_valid);

    // ----------------------------------------
    // All-axes servo-on command
    // ----------------------------------------

    // Writes during positioning are dropped; forced stop wins over a write
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            all_axes_servo_on_cmd_o <= `MAF_SERVO_ON_RESET;
        end else if (forced_stop_i) begin
            all_axes_servo_on_cmd_o <= 1'b0;
        end else if (servo_on_wr_i && !any_positioning) begin
            all_axes_servo_on_cmd_o <= servo_on_val_i;
        end
    end
    // run_stopped_i deliberately has no path to the command above

    // Acceptance does not wait on any axis being ready
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            servo_on_accept_flag_o <= 1'b0;
        end else begin
            servo_on_accept_flag_o <= all_axes_servo_on_cmd_o & ~forced_stop_i;
        end
    end

    // Per-axis enable gated by command, off request, error and stop
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            servo_enable_o <= '0;
        end else if (forced_stop_i) begin
            servo_enable_o <= '0;
        end else begin
            servo_enable_o <= {AXES{all_axes_servo_on_cmd_o}} & ~axis_servo_off_cmd_i
                & ~axis_servo_error_i & axis_valid;
        end
    end

    // ----------------------------------------
    // Slot supervision
    // ----------------------------------------

    // Only configured slots take part in the check
    assign slot_bad_now = |(slot_module_bad_i & slot_configured_i);

    // Flag tracks the check every cycle, starting right after reset
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            slot_fault_flag_o <= 1'b0;
            slot_fault_prev <= 1'b0;
        end else begin
            slot_fault_flag_o <= slot_bad_now;
            slot_fault_prev <= slot_fault_flag_o;
        end
    end

    assign slot_fault_edge = slot_fault_flag_o ^ slot_fault_prev;

    // Unconfigured slots are never granted
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            slot_use_grant_o <= '0;
        end else begin
            slot_use_grant_o <= slot_use_req_i & slot_configured_i;
        end
    end

    // Lockout outlives the flag itself; only reset releases it
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            start_lockout_o <= 1'b0;
        end else if (slot_fault_flag_o) begin
            start_lockout_o <= 1'b1;
        end
    end

    // Starts refused while the flag or the lockout stands
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            axis_start_grant_o <= '0;
        end else if (slot_fault_flag_o || start_lockout_o) begin
            axis_start_grant_o <= '0;
        end else begin
            axis_start_grant_o <= axis_start_req_i & axis_valid;
        end
    end

    // ----------------------------------------
    // Simultaneous jog
    // ----------------------------------------

    // Only the low word bits map to axes; the rest is ignored
    assign jog_select = jog_axis_select_words_i[AXES-1:0] & axis_valid;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            jog_cmd_prev <= 1'b0;
        end else begin
            jog_cmd_prev <= jog_simultaneous_start_cmd_i;
        end
    end

    assign jog_rise = jog_simultaneous_start_cmd_i & ~jog_cmd_prev;
    assign jog_fall = ~jog_simultaneous_start_cmd_i & jog_cmd_prev;

    // One-cycle start pulse to all selected axes at once
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            jog_start_o <= '0;
        end else if (jog_rise && !start_lockout_o && !slot_fault_flag_o) begin
            jog_start_o <= jog_select;
        end else begin
            jog_start_o <= '0;
        end
    end

    // Remember which axes this command launched
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            jog_owned <= '0;
        end else if (jog_rise && !start_lockout_o && !slot_fault_flag_o) begin
            jog_owned <= jog_select;
        end else if (jog_fall) begin
            jog_owned <= '0;
        end
    end

    // Decelerated stop requests: jog release or slot flag change
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            decel_stop_o <= '0;
        end else begin
            decel_stop_o <= ({AXES{jog_fall}} & jog_owned)
                | ({AXES{slot_fault_edge}} & axis_moving_i & axis_valid);
        end
    end

    // ----------------------------------------
    // Pulse generators
    // ----------------------------------------

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pulse_generator_enables_o <= `MAF_MPG_EN_RESET;
        end else if (pulse_generator_enables_wr_i) begin
            pulse_generator_enables_o <= pulse_generator_enables_val_i;
        end
    end

    // Input pulses pass only while their enable is set
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pulse_generator_pulse_o <= '0;
        end else begin
            pulse_generator_pulse_o <= pulse_generator_pulse_i & pulse_generator_enables_o;
        end
    end

    // ----------------------------------------
    // Cycle overrun
    // ----------------------------------------

    assign overrun_now = cycle_done_i && (cycle_time_i > operation_cycle_setting_i);

    // Sticky; a new overrun in the clearing cycle still sets it
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cycle_overrun_flag_o <= 1'b0;
        end else if (overrun_now) begin
            cycle_overrun_flag_o <= 1'b1;
        end else if (user_program_reset_i) begin
            cycle_overrun_flag_o <= 1'b0;
        end
    end

    // ----------------------------------------
    // Per-axis flag cells
    // ----------------------------------------

    generate
        for (g = 0; g < AXES; g = g + 1) begin : g_axis
            maf_axis_cell u_cell (
                .core_clk_i(core_clk_i),
                .rst_i(rst_i),
                .axis_valid_i(axis_valid[g]),
                .seq_speed_change_start_i(speed_change_instruction_i[g]),
                .host_speed_change_start_i(host_speed_change_instruction_i[g]),
                .speed_change_done_i(speed_change_done_i[g]),
                .mode_i(axis_mode_i[g]),
                .auto_decel_active_i(auto_decel_active_i[g]),
                .scurve_early_decel_i(scurve_early_decel_i[g]),
                .stop_decel_i(stop_decel_i[g]),
                .travel_zero_i(travel_zero_i[g]),
                .cmd_addr_change_i(cmd_addr_change_i[g]),
                .start_complete_i(start_complete_i[g]),
                .speed_change_accepting_o(speed_change_accepting_flags_o[g]),
                .auto_decelerating_o(auto_decelerating_flags_o[g])
            );
        end
    endgenerate

endmodule

//--- hdl/maf_map.svh
// Behaviour
// - Servo enabled only with command, no off, no error
// - Forced stop clears command; stop or error disables
// - Servo-on command changes ignored while positioning
// - Command stays set in stopped run state
// - Slot fault flag follows continuous module check
// - Unconfigured slots excluded from check and use
// - Slot fault flag change decelerates moving axes
// - Slot fault blocks starts until reset
// - Jog command rise starts all selected axes
// - Jog command fall decelerates axes it started
// - Accept flag set without per-axis readiness check
// - Pulse generator inputs gated by enables, reset clear
// - Sticky overrun flag when processing exceeds cycle
// - Speed-change flag only for sequence instruction
// - Per-axis flags for 32 axes, fewer valid
// - Decelerating flag held during automatic deceleration
// - Follow-up: flag clears on command address change
// - Constant speed: flag set decelerating to final point
// - Flag clears at normal start completion
// - Flag may set during S-curve acceleration
// - Flag never set for jog, generator, stop, zero travel
`ifndef MAF_MAP_SVH
`define MAF_MAP_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define MAF_AXES_MAX 32
`define MAF_AXES_MID 16
`define MAF_AXES_SMALL 8
`define MAF_SLOTS 8
`define MAF_JOG_WORDS 4
`define MAF_JOG_WORD_W 16
`define MAF_MPG_COUNT 3
`define MAF_CYCLE_W 16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MAF_MPG_EN_RESET 3'h0
`define MAF_SERVO_ON_RESET 1'h0

`endif

//--- hdl/maf_pkg.sv
package maf_pkg;

    // ----------------------------------------
    // Motion modes reported per axis
    // ----------------------------------------
    typedef enum logic [2:0] {
        MAF_MODE_IDLE = 3'h0,
        MAF_MODE_POSITIONING = 3'h1,
        MAF_MODE_FOLLOW_UP = 3'h2,
        MAF_MODE_CONST_SPEED = 3'h3,
        MAF_MODE_JOG = 3'h4,
        MAF_MODE_PULSE_GEN = 3'h5
    } maf_motion_mode_t;

endpackage
